/* File: verilog/seh_exception_handler.sv */
// sensor exception handler: reset-class and flag-class conditions
// assumes condition pins asynchronous, command strobes on clk
`timescale 1ns/1ps
`include "seh_defines.svh"
module seh_exception_handler #(
  parameter int unsigned CAP_RESET_CYC = `SEH_CAP_RESET_CYC,
  parameter int unsigned CAP_CHECK_CYC = `SEH_CAP_CHECK_CYC,
  parameter int unsigned FRAME_TO_CYC  = `SEH_FRAME_TO_CYC
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // condition pins (asynchronous)
  input  wire seh_pkg::seh_cond_t cond_pins,
  input  wire logic               factory_seal,
  input  wire logic               user_seal,
  // decoded commands
  input  wire logic               cmd_valid,
  input  wire seh_pkg::seh_cmd_t  cmd,
  input  wire logic [3:0]         dev_addr,
  // device control
  output logic                    dev_reset,
  output logic                    need_reinit,
  output logic                    dsi_answer_en,
  output logic                    bus_switch_close,
  output logic                    selftest_drive,
  output seh_pkg::seh_flags_t     flags,
  output seh_pkg::seh_resp_t      short_resp,
  output seh_pkg::seh_resp_t      long_resp,
  // register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata,
  output logic                    irq
);
  import seh_pkg::*;

  // assertions below all sample on clk and sleep during reset
  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  seh_cond_t  meta_ff;
  seh_cond_t  sync_ff;
  logic [1:0] seal_meta_ff;
  logic [1:0] seal_sync_ff;
  logic       st_on_ff;
  logic       lockout_ff;
  logic       last_dis_ff;
  logic       reinit_ff;
  logic [7:0] pulse_ff;
  logic [3:0] status_ff;
  logic [3:0] mask_ff;
  logic [3:0] nxt_events;
  seh_flags_t prev_flags_ff;
  logic       prev_lock_ff;
  logic       cap_long;
  logic       cap_tick;
  logic       chk_tick;
  logic       bus_long;
  logic       bus_tick;
  logic       supply_uv;
  logic       reset_class;
  logic       crc_fault;
  logic       fault_any;
  logic       st_cmd_ok;
  logic       rereset;

  // two-flop synchronisers for all pin conditions and seal bits
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_ff      <= '0;
      sync_ff      <= '0;
      seal_meta_ff <= 2'h0;
      seal_sync_ff <= 2'h0;
    end
    else
    begin
      meta_ff      <= cond_pins;
      sync_ff      <= meta_ff;
      seal_meta_ff <= {factory_seal, user_seal};
      seal_sync_ff <= seal_meta_ff;
    end
  end

  // period timers for the three repeating reset sources
  seh_period_timer #(.PERIOD(CAP_RESET_CYC)) u_cap_timer (
    .clk     (clk),
    .arst_n  (arst_n),
    .armed   (sync_ff.cap_low),
    .expired (cap_long),
    .tick    (cap_tick)
  );
  seh_period_timer #(.PERIOD(CAP_CHECK_CYC)) u_chk_timer (
    .clk     (clk),
    .arst_n  (arst_n),
    .armed   (sync_ff.cap_check_fail),
    .expired (),
    .tick    (chk_tick)
  );
  seh_period_timer #(.PERIOD(FRAME_TO_CYC)) u_bus_timer (
    .clk     (clk),
    .arst_n  (arst_n),
    .armed   (sync_ff.bus_low),
    .expired (bus_long),
    .tick    (bus_tick)
  );

  // reset-class classification
  assign supply_uv   = sync_ff.core_uv | sync_ff.analog_uv;
  assign reset_class = supply_uv | cap_long
                     | sync_ff.cap_check_fail | bus_long;
  // long cap dip and bus timeout yield to supply undervoltage
  assign rereset = !supply_uv & ((cap_tick & cap_long)
                 | chk_tick
                 | (bus_tick & bus_long));

  // internal reset: held for supply, pulsed at each re-reset period
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pulse_ff <= 8'h0;
    else if (rereset)
      pulse_ff <= 8'(`SEH_RST_PULSE_CYC);
    else if (pulse_ff != 8'h0)
      pulse_ff <= pulse_ff - 8'h1;
  end
  assign dev_reset = supply_uv | (pulse_ff != 8'h0);

  // re-initialisation required after any reset-class event
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reinit_ff <= 1'b1;
    else if (reset_class)
      reinit_ff <= 1'b1;
    else if (cmd_valid && cmd.clear)
      reinit_ff <= 1'b0;
  end
  assign need_reinit = reinit_ff;

  // no answers while any reset-class condition holds
  assign dsi_answer_en = !reset_class && !dev_reset;

  // bus switch opens the same cycle the condition is seen, so the
  // opening time is met without a counter
  assign bus_switch_close = !reset_class && !reinit_ff;

  // self-test command acceptance: own address only, never global
  assign st_cmd_ok = cmd_valid && (cmd.addr == dev_addr)
                   && (cmd.addr != 4'h0);

  // self-test state and lockout
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_on_ff    <= 1'b0;
      lockout_ff  <= 1'b0;
      last_dis_ff <= 1'b0;
    end
    else if (reset_class || dev_reset)
    begin
      st_on_ff    <= 1'b0;
      lockout_ff  <= 1'b0;
      last_dis_ff <= 1'b0;
    end
    else if (cmd_valid && cmd.clear)
    begin
      st_on_ff    <= 1'b0;
      lockout_ff  <= 1'b0;
      last_dis_ff <= 1'b0;
    end
    else if (st_cmd_ok && cmd.st_disable)
    begin
      st_on_ff    <= 1'b0;
      last_dis_ff <= 1'b1;
      if (last_dis_ff)
        lockout_ff <= 1'b1;
    end
    else if (st_cmd_ok && cmd.st_enable)
    begin
      st_on_ff    <= !lockout_ff;
      last_dis_ff <= 1'b0;
    end
    else if (cmd_valid)
      last_dis_ff <= 1'b0;
  end
  assign selftest_drive = st_on_ff && !lockout_ff;

  // flag-class faults combine by OR
  assign crc_fault = (sync_ff.crc_factory && seal_sync_ff[1])
                   | (sync_ff.crc_user && seal_sync_ff[0]);
  assign fault_any = crc_fault | sync_ff.temp_bad
                   | selftest_drive;

  // status flags in responses
  always_comb
  begin
    flags = '0;
    if (fault_any)
    begin
      flags.fault_flag       = 1'b1;
      flags.diag_active_flag = selftest_drive;
    end
    else if (sync_ff.cap_low)
    begin
      flags.hold_cap_low_flag = 1'b1;
      flags.diag_active_flag  = selftest_drive;
    end
    // selftest sets diag; a cap dip alone shows caplow and clears fault
    if (selftest_drive)
    begin
      flags.fault_flag       = !sync_ff.cap_low || crc_fault
                             || sync_ff.temp_bad;
      flags.diag_active_flag = 1'b1;
      flags.hold_cap_low_flag = sync_ff.cap_low && !crc_fault
                              && !sync_ff.temp_bad;
    end
  end

  // acceleration response substitution
  always_comb
  begin
    short_resp = SEH_RESP_NORMAL;
    long_resp  = SEH_RESP_NORMAL;
    if (selftest_drive)
    begin
      short_resp = SEH_RESP_SELFTEST;
      long_resp  = SEH_RESP_SELFTEST;
    end
    if (crc_fault || sync_ff.temp_bad)
      short_resp = SEH_RESP_ZERO;
    else if (sync_ff.cap_low && !selftest_drive)
      short_resp = SEH_RESP_ZERO;
  end

  // interrupt events on rising edges of the fault and cap-low flags and of lockout, and on reset activity
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_flags_ff <= '0;
      prev_lock_ff  <= 1'b0;
    end
    else
    begin
      prev_flags_ff <= flags;
      prev_lock_ff  <= lockout_ff;
    end
  end
  always_comb
  begin
    nxt_events = 4'h0;
    nxt_events[`SEH_EV_RESET]   = rereset | (supply_uv & !reinit_ff);
    nxt_events[`SEH_EV_FAULT]   = flags.fault_flag
                                & !prev_flags_ff.fault_flag;
    nxt_events[`SEH_EV_CAPLOW]  = flags.hold_cap_low_flag
                                & !prev_flags_ff.hold_cap_low_flag;
    nxt_events[`SEH_EV_LOCKOUT] = lockout_ff & !prev_lock_ff;
  end

  // sticky status, write one to clear, set wins over clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      status_ff <= 4'h0;
    else if (reg_wr && reg_addr == `SEH_ADDR_STATUS)
      status_ff <= (status_ff & ~reg_wdata[3:0]) | nxt_events;
    else
      status_ff <= status_ff | nxt_events;
  end

  // mask register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mask_ff <= `SEH_MASK_RESET_VAL;
    else if (reg_wr && reg_addr == `SEH_ADDR_MASK)
      mask_ff <= reg_wdata[3:0];
  end
  assign irq = |(status_ff & mask_ff);

  // register read, data one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h0;
    else if (!reg_rd)
      reg_rdata <= 8'h0;
    else if (reg_addr == `SEH_ADDR_STATUS)
      reg_rdata <= {4'h0, status_ff};
    else if (reg_addr == `SEH_ADDR_MASK)
      reg_rdata <= {4'h0, mask_ff};
    else if (reg_addr == `SEH_ADDR_FLAGS)
      reg_rdata <= {lockout_ff, selftest_drive, need_reinit, dev_reset,
                    1'b0, flags};
    else if (reg_addr == `SEH_ADDR_COND)
      reg_rdata <= sync_ff;
    else
      reg_rdata <= 8'h0;
  end

  // assertions
  a_supply_holds_reset: assert property (
    supply_uv |-> dev_reset)
    else $error("supply undervoltage without reset");
  a_reset_no_answer: assert property (
    reset_class |-> !dsi_answer_en && !bus_switch_close)
    else $error("answer or switch closed under reset class");
  a_cap_short_flags: assert property (
    sync_ff.cap_low && !cap_long && !fault_any |->
      flags.hold_cap_low_flag && short_resp == SEH_RESP_ZERO)
    else $error("short cap dip flags wrong");
  a_cap_st_data: assert property (
    sync_ff.cap_low && selftest_drive && !crc_fault && !sync_ff.temp_bad |->
      short_resp == SEH_RESP_SELFTEST && flags.diag_active_flag)
    else $error("cap dip under selftest wrong");
  a_rereset_pulse: assert property (
    rereset |=> dev_reset [*4])
    else $error("re-reset pulse too short");
  a_crc_short_zero: assert property (
    crc_fault |-> flags.fault_flag && short_resp == SEH_RESP_ZERO)
    else $error("crc fault not reported");
  a_temp_long_resp: assert property (
    sync_ff.temp_bad |-> long_resp ==
      (selftest_drive ? SEH_RESP_SELFTEST : SEH_RESP_NORMAL))
    else $error("temperature long response wrong");
  a_lockout_set: assert property (
    st_cmd_ok && cmd.st_disable && last_dis_ff && !cmd.clear && !dev_reset
      && !reset_class |=> lockout_ff && !selftest_drive)
    else $error("lockout not entered");
  a_lockout_clear: assert property (
    cmd_valid && cmd.clear |=> !lockout_ff)
    else $error("lockout survived clear");
  a_global_ignored: assert property (
    cmd_valid && cmd.st_enable && cmd.addr == 4'h0 && !st_on_ff
      |=> !st_on_ff)
    else $error("global enable accepted");
  c_lockout: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(lockout_ff));
  c_rereset: cover property (@(posedge clk) disable iff (!arst_n) rereset);
  c_selftest: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(selftest_drive));
endmodule : seh_exception_handler

/* File: verilog/seh_defines.svh */
// constants for the sensor exception handler
// assumes a 20 MHz core clock; counts are derived from times in ns
`ifndef SEH_DEFINES_SVH
`define SEH_DEFINES_SVH

`define SEH_CLK_PERIOD_NS        50
// time after which a held condition counts as long, and re-reset period
`define SEH_CAP_RESET_PERIOD_NS  1000000
`define SEH_CAP_CHECK_PERIOD_NS  1000000
`define SEH_FRAME_TIMEOUT_NS     1000000
// bus switch opening time (longest)
`define SEH_SWITCH_OPEN_TIME_NS  500
`define SEH_SWITCH_OPEN_CYC \
  ((`SEH_SWITCH_OPEN_TIME_NS / `SEH_CLK_PERIOD_NS) < 1 ? 1 : \
   (`SEH_SWITCH_OPEN_TIME_NS / `SEH_CLK_PERIOD_NS))
// least times rounded up to whole cycles
`define SEH_CAP_RESET_CYC \
  ((`SEH_CAP_RESET_PERIOD_NS + `SEH_CLK_PERIOD_NS - 1) / `SEH_CLK_PERIOD_NS)
`define SEH_CAP_CHECK_CYC \
  ((`SEH_CAP_CHECK_PERIOD_NS + `SEH_CLK_PERIOD_NS - 1) / `SEH_CLK_PERIOD_NS)
`define SEH_FRAME_TO_CYC \
  ((`SEH_FRAME_TIMEOUT_NS + `SEH_CLK_PERIOD_NS - 1) / `SEH_CLK_PERIOD_NS)
// length of the internal reset pulse issued at each re-reset
`define SEH_RST_PULSE_CYC        4
// register offsets
`define SEH_ADDR_STATUS          4'h0
`define SEH_ADDR_MASK            4'h1
`define SEH_ADDR_FLAGS           4'h2
`define SEH_ADDR_COND            4'h3
// interrupt event bit positions
`define SEH_EV_RESET             0
`define SEH_EV_FAULT             1
`define SEH_EV_CAPLOW            2
`define SEH_EV_LOCKOUT           3
`define SEH_MASK_RESET_VAL       4'h0

`endif

/* File: verilog/seh_pkg.sv */
// types for the sensor exception handler
// assumes seh_defines.svh supplies the numeric constants
package seh_pkg;
  // response substitution per acceleration read length
  typedef enum logic [1:0] {SEH_RESP_NORMAL, SEH_RESP_ZERO,
                            SEH_RESP_SELFTEST} seh_resp_t;
  // raw condition inputs, synchronised inside the block before use
  typedef struct packed {
    logic core_uv;
    logic analog_uv;
    logic cap_low;
    logic cap_check_fail;
    logic bus_low;
    logic crc_factory;
    logic crc_user;
    logic temp_bad;
  } seh_cond_t;
  // decoded commands from the command decoder
  typedef struct packed {
    logic       st_enable;
    logic       st_disable;
    logic       clear;
    logic       other;
    logic [3:0] addr;
  } seh_cmd_t;
  // flags reported in responses
  typedef struct packed {
    logic fault_flag;
    logic diag_active_flag;
    logic hold_cap_low_flag;
  } seh_flags_t;
endpackage : seh_pkg

/* File: verilog/seh_period_timer.sv */
// period timer: counts while armed, pulses at each full period
// assumes one clock domain, armed input from same-clock logic
`timescale 1ns/1ps
module seh_period_timer #(
  parameter int unsigned PERIOD = 20000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // control
  input  wire logic armed,
  // status
  output logic      expired,
  output logic      tick
);
  logic [31:0] cnt_ff;

  // count up while armed, wrap each period
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff <= 32'h0;
      tick   <= 1'b0;
    end
    else if (!armed)
    begin
      cnt_ff <= 32'h0;
      tick   <= 1'b0;
    end
    else if (cnt_ff == PERIOD - 1)
    begin
      cnt_ff <= 32'h0;
      tick   <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 32'h1;
      tick   <= 1'b0;
    end
  end

  // expired stays high once a period has elapsed while armed
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      expired <= 1'b0;
    else if (!armed)
      expired <= 1'b0;
    else if (cnt_ff == PERIOD - 1)
      expired <= 1'b1;
  end
endmodule : seh_period_timer

/* File: bench/seh_dsi_master.sv */
// behavioural bus master: sends decoded commands to the handler
// assumes the handler takes a command on the rising edge with cmd_valid
`timescale 1ns/1ps
module seh_dsi_master (
  // clock
  input  wire logic      clk,
  // command out
  output logic              cmd_valid,
  output seh_pkg::seh_cmd_t cmd
);
  import seh_pkg::*;

  // idle until the bench asks for a command
  initial
  begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // one-cycle strobe, then two cycles so the answer can settle
  task automatic send(input logic en, input logic dis, input logic clr,
                      input logic [3:0] a);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= '{st_enable: en, st_disable: dis, clear: clr,
                   other: 1'b0, addr: a};
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd       <= '0;
    repeat (2) @(posedge clk);
  endtask : send
endmodule : seh_dsi_master

/* File: bench/tb_seh_exception_handler.sv */
// bench for the exception handler: conditions, commands, registers
// assumes the partner model drives commands; periods shortened to 16
`timescale 1ns/1ps
`include "seh_defines.svh"
module tb_seh_exception_handler;
  import seh_pkg::*;
  localparam int unsigned PER  = 16;
  localparam logic [3:0]  ADDR = 4'h5;
  logic       clk = 1'b0;
  logic       arst_n;
  seh_cond_t  cond_pins;
  logic       factory_seal;
  logic       user_seal;
  logic       cmd_valid;
  seh_cmd_t   cmd;
  logic       dev_reset;
  logic       need_reinit;
  logic       dsi_answer_en;
  logic       bus_switch_close;
  logic       selftest_drive;
  seh_flags_t flags;
  seh_resp_t  short_resp;
  seh_resp_t  long_resp;
  logic [3:0] dev_addr;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       irq;
  logic [7:0] rd;
  logic [7:0] rc [3] = '{8'h20, 8'h10, 8'h08};
  logic [7:0] uv [2] = '{8'h81, 8'h40};
  logic [7:0] fc [4] = '{8'h04, 8'h02, 8'h01, 8'h07};
  int         n_mismatch = 0;
  int         samples_checked = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  seh_exception_handler #(.CAP_RESET_CYC(PER), .CAP_CHECK_CYC(PER),
                          .FRAME_TO_CYC(PER)) u_seh_exception_handler (
    .clk(clk), .arst_n(arst_n), .cond_pins(cond_pins),
    .factory_seal(factory_seal), .user_seal(user_seal),
    .cmd_valid(cmd_valid), .cmd(cmd), .dev_addr(dev_addr),
    .dev_reset(dev_reset), .need_reinit(need_reinit),
    .dsi_answer_en(dsi_answer_en), .bus_switch_close(bus_switch_close),
    .selftest_drive(selftest_drive), .flags(flags),
    .short_resp(short_resp), .long_resp(long_resp),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  seh_dsi_master u_seh_dsi_master (
    .clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));

  // compare and count
  task automatic check(input string name, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // wait n edges and let their updates land
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic snd(input logic en, dis, clr, input logic [3:0] a);
    u_seh_dsi_master.send(en, dis, clr, a);
    #1;
  endtask : snd

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // condition pins pass a two-flop synchroniser
  task automatic pins(input logic [7:0] v);
    @(posedge clk);
    cond_pins <= seh_cond_t'(v);
    tick(4);
  endtask : pins

  task automatic resp_chk(input logic [2:0] f, input seh_resp_t s, l);
    check("flags", {5'h0, flags}, {5'h0, f});
    check("short_resp", {6'h0, short_resp}, {6'h0, s});
    check("long_resp", {6'h0, long_resp}, {6'h0, l});
  endtask : resp_chk

  // bounded wait for the internal reset to reach a level
  task automatic wait_rst(input logic v, input int maxc);
    int k;
    k = 0;
    while (dev_reset !== v && k < maxc)
    begin
      tick(1);
      k++;
    end
    check("dev_reset", {7'h0, dev_reset}, {7'h0, v});
  endtask : wait_rst

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  // main sequence
  initial
  begin
    arst_n = 1'b0;
    cond_pins = '0;
    factory_seal = 1'b1;
    user_seal = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dev_addr = ADDR;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    tick(1);
    check("reinit_at_reset", {7'h0, need_reinit}, 8'h01);
    reg_read(`SEH_ADDR_MASK, rd);
    check("mask_reset", rd, 8'h00);
    reg_read(4'hf, rd);
    check("unmapped", rd, 8'h00);
    snd(0, 0, 1, ADDR);
    check("reinit", {7'h0, need_reinit}, 8'h00);
    check("answer_en", {7'h0, dsi_answer_en}, 8'h01);
    resp_chk(3'b000, SEH_RESP_NORMAL, SEH_RESP_NORMAL);
    // flag-only faults with self-test off, singly and together
    foreach (fc[i])
    begin
      pins(fc[i]);
      resp_chk(3'b100, SEH_RESP_ZERO, SEH_RESP_NORMAL);
      pins(8'h00);
    end
    pins(8'h20);
    resp_chk(3'b001, SEH_RESP_ZERO, SEH_RESP_NORMAL);
    pins(8'h00);
    check("reinit", {7'h0, need_reinit}, 8'h00);
    snd(1, 0, 0, 4'h0);
    check("st_global", {7'h0, selftest_drive}, 8'h00);
    // an unprogrammed address of zero must still refuse the global enable
    @(posedge clk);
    dev_addr <= 4'h0;
    snd(1, 0, 0, 4'h0);
    check("st_global0", {7'h0, selftest_drive}, 8'h00);
    @(posedge clk);
    dev_addr <= ADDR;
    snd(1, 0, 0, ADDR);
    check("st_on", {7'h0, selftest_drive}, 8'h01);
    resp_chk(3'b110, SEH_RESP_SELFTEST, SEH_RESP_SELFTEST);
    pins(8'h20);
    resp_chk(3'b011, SEH_RESP_SELFTEST, SEH_RESP_SELFTEST);
    pins(8'h04);
    resp_chk(3'b110, SEH_RESP_ZERO, SEH_RESP_SELFTEST);
    pins(8'h01);
    resp_chk(3'b110, SEH_RESP_ZERO, SEH_RESP_SELFTEST);
    pins(8'h00);
    // lockout after two disables, with its interrupt event
    snd(0, 1, 0, ADDR);
    snd(0, 1, 0, ADDR);
    reg_write(`SEH_ADDR_MASK, 8'h08);
    snd(1, 0, 0, ADDR);
    check("st_locked", {7'h0, selftest_drive}, 8'h00);
    resp_chk(3'b000, SEH_RESP_NORMAL, SEH_RESP_NORMAL);
    check("irq", {7'h0, irq}, 8'h01);
    reg_read(`SEH_ADDR_STATUS, rd);
    check("status", rd & 8'h08, 8'h08);
    reg_write(`SEH_ADDR_STATUS, 8'h08);
    tick(1);
    check("irq_clear", {7'h0, irq}, 8'h00);
    snd(0, 0, 1, ADDR);
    snd(1, 0, 0, ADDR);
    check("st_unlock", {7'h0, selftest_drive}, 8'h01);
    snd(0, 1, 0, ADDR);
    // long cap dip, cap check failure, bus low: repeating resets
    foreach (rc[i])
    begin
      pins(rc[i]);
      wait_rst(1'b1, 40);
      check("answer_en", {7'h0, dsi_answer_en}, 8'h00);
      check("switch", {7'h0, bus_switch_close}, 8'h00);
      wait_rst(1'b0, 8);
      wait_rst(1'b1, PER + 8);
      pins(8'h00);
      tick(40);
      check("dev_reset", {7'h0, dev_reset}, 8'h00);
      check("reinit", {7'h0, need_reinit}, 8'h01);
      snd(0, 0, 1, ADDR);
      check("switch", {7'h0, bus_switch_close}, 8'h01);
    end
    // reset, fault and cap-low events all left sticky status bits
    reg_read(`SEH_ADDR_STATUS, rd);
    check("status_ev", rd & 8'h07, 8'h07);
    // regulator undervoltage holds reset for its whole length
    foreach (uv[i])
    begin
      pins(uv[i]);
      check("dev_reset", {7'h0, dev_reset}, 8'h01);
      check("answer_en", {7'h0, dsi_answer_en}, 8'h00);
      tick(3 * PER);
      check("dev_reset", {7'h0, dev_reset}, 8'h01);
      pins(8'h00);
      check("reinit", {7'h0, need_reinit}, 8'h01);
      snd(0, 0, 1, ADDR);
    end
    give_verdict();
  end
endmodule : tb_seh_exception_handler
